// File: shared/packed_shift_regs.svh
`ifndef PACKED_SHIFT_REGS_SVH
`define PACKED_SHIFT_REGS_SVH
`define PSH_OPC_MSB 31
`define PSH_OPC_LSB 26
`define PSH_OPC_VAL 6'h08
`define PSH_RT_MSB 25
`define PSH_RT_LSB 21
`define PSH_RS_MSB 20
`define PSH_RS_LSB 16
`define PSH_RD_MSB 15
`define PSH_RD_LSB 11
`define PSH_QB_SA_MSB 15
`define PSH_QB_SA_LSB 13
`define PSH_QB_RND_BIT 12
`define PSH_QB_TAIL_VAL 12'h1ff
`define PSH_PH_SA_MSB 15
`define PSH_PH_SA_LSB 12
`define PSH_RND_BIT 10
`define PSH_SUB_MSB 9
`define PSH_SUB_LSB 3
`define PSH_SUB_FIX_PH 7'h66
`define PSH_SUB_VAR_PH 7'h31
`define PSH_SUB_VAR_QB 7'h39
`define PSH_POOL_VAL 3'h5
`define PSH_QB_TAIL_MSB 11
`define PSH_QB_TAIL_LSB 0
`define PSH_POOL_MSB 2
`define PSH_POOL_LSB 0
`define PSH_QB_CNT_MSB 2
`define PSH_PH_CNT_MSB 3
`define PSH_CNT_LSB 0
`define PSH_RESULT_RST 32'h0000_0000
`define PSH_DEST_RST 5'h00
`define PSH_EXC_NONE 2'h0
`define PSH_EXC_RESERVED 2'h1
`define PSH_EXC_DSP_OFF 2'h2
`endif

// File: shared/packed_shift_pkg.sv
package packed_shift_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_FIX_QB = 4'b0001,
    OP_FIX_QB_R = 4'b0010,
    OP_FIX_PH = 4'b0011,
    OP_FIX_PH_R = 4'b0100,
    OP_VAR_PH = 4'b0101,
    OP_VAR_PH_R = 4'b0110,
    OP_VAR_QB = 4'b0111,
    OP_VAR_QB_R = 4'b1000
  } shift_op_e;
  typedef logic [1:0] exc_code_t;
endpackage : packed_shift_pkg

// File: rtl/lane_arith_shift.sv
`timescale 1ns/1ps
`default_nettype none
// one signed lane: arithmetic right shift, optional rounding
module lane_arith_shift #(
  parameter int WIDTH = 8,
  parameter int SW = 3
) (
  input wire logic [WIDTH-1:0] value_in,
  input wire logic [SW-1:0] amount_in,
  input wire logic round_in,
  output logic [WIDTH-1:0] result_out
);
  logic [WIDTH:0] ext;
  logic signed [WIDTH:0] shifted;
  logic [WIDTH:0] rnd;
  always_comb begin
    // shifting value||0 by amount keeps the top discarded bit at bit 0
    ext = {value_in, 1'b0};
    shifted = '0;
    rnd = '0;
    if (amount_in == '0) begin
      result_out = value_in;
    end else if (round_in) begin
      shifted = $signed(ext) >>> amount_in;
      rnd = shifted + (WIDTH+1)'(1);
      result_out = rnd[WIDTH:1];
    end else begin
      result_out = WIDTH'($signed(value_in) >>> amount_in);
    end
  end
endmodule : lane_arith_shift
`default_nettype wire

// File: rtl/packed_arith_right_shifter.sv
`timescale 1ns/1ps
`default_nettype none
`include "packed_shift_regs.svh"
// Functional notes
// - fixed byte shift, four lanes independently
// - fixed byte amount is three bits
// - byte rounding adds one at top discard
// - decode fixed byte form and tail
// - fixed halfword shift with sign replication
// - decode fixed halfword form, four-bit amount
// - halfword rounding adds one at top discard
// - halfword rounding uses 17-bit increment
// - variable halfword shift of target register
// - variable halfword count from source bits 3..0
// - decode variable halfword form
// - variable byte count from source bits 2..0
// - no data-dependent exceptions
// - check DSP access, else raise exception
module packed_arith_right_shifter (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic issue_in,
  input wire logic [31:0] instr_in,
  input wire logic [31:0] source_field_in,
  input wire logic [31:0] target_field_in,
  input wire logic dsp_present_in,
  input wire logic dsp_enabled_in,
  output logic done_out,
  output logic [31:0] result_out,
  output logic [4:0] dest_reg_out,
  output logic write_en_out,
  output logic [1:0] exc_out,
  output logic decoded_out
);
  // ==================================================================
  // helpers
  // plain or rounding member of a form, picked by its rounding bit
  function automatic packed_shift_pkg::shift_op_e pick_form(
    input logic rnd,
    input packed_shift_pkg::shift_op_e plain,
    input packed_shift_pkg::shift_op_e rounded
  );
    return rnd ? rounded : plain;
  endfunction : pick_form

  function automatic logic is_shift_op(
    input packed_shift_pkg::shift_op_e o
  );
    return o != packed_shift_pkg::OP_NONE;
  endfunction : is_shift_op

  // ==================================================================
  // decode
  packed_shift_pkg::shift_op_e op;
  logic known;
  logic [4:0] dest;
  logic [4:0] tgt_idx;
  logic [4:0] dst_idx;
  logic [6:0] sub;
  assign sub = instr_in[`PSH_SUB_MSB:`PSH_SUB_LSB];
  assign tgt_idx = instr_in[`PSH_RT_MSB:`PSH_RT_LSB];
  assign dst_idx = instr_in[`PSH_RD_MSB:`PSH_RD_LSB];

  // the fixed byte tail is tested first: it has no pool code in bits 2..0
  always_comb begin
    op = packed_shift_pkg::OP_NONE;
    dest = '0;
    if (instr_in[`PSH_OPC_MSB:`PSH_OPC_LSB] != `PSH_OPC_VAL) begin
      op = packed_shift_pkg::OP_NONE;
    end else if (instr_in[`PSH_QB_TAIL_MSB:`PSH_QB_TAIL_LSB]
                 == `PSH_QB_TAIL_VAL) begin
      op = pick_form(instr_in[`PSH_QB_RND_BIT], packed_shift_pkg::OP_FIX_QB,
                     packed_shift_pkg::OP_FIX_QB_R);
      dest = tgt_idx;
    end else if (instr_in[`PSH_POOL_MSB:`PSH_POOL_LSB] != `PSH_POOL_VAL) begin
      op = packed_shift_pkg::OP_NONE;
    end else if (sub == `PSH_SUB_FIX_PH) begin
      op = pick_form(instr_in[`PSH_RND_BIT], packed_shift_pkg::OP_FIX_PH,
                     packed_shift_pkg::OP_FIX_PH_R);
      dest = tgt_idx;
    end else if (sub == `PSH_SUB_VAR_PH) begin
      op = pick_form(instr_in[`PSH_RND_BIT], packed_shift_pkg::OP_VAR_PH,
                     packed_shift_pkg::OP_VAR_PH_R);
      dest = dst_idx;
    end else if (sub == `PSH_SUB_VAR_QB) begin
      op = pick_form(instr_in[`PSH_RND_BIT], packed_shift_pkg::OP_VAR_QB,
                     packed_shift_pkg::OP_VAR_QB_R);
      dest = dst_idx;
    end
  end
  assign known = is_shift_op(op);

  // ==================================================================
  // operand selection
  logic byte_mode;
  logic fixed_form;
  logic round_sel;
  logic [31:0] operand;
  logic [2:0] qb_amt;
  logic [3:0] ph_amt;

  always_comb begin
    byte_mode = 1'b0;
    fixed_form = 1'b0;
    round_sel = 1'b0;
    case (op)
      packed_shift_pkg::OP_FIX_QB: begin
        byte_mode = 1'b1;
        fixed_form = 1'b1;
      end
      packed_shift_pkg::OP_FIX_QB_R: begin
        byte_mode = 1'b1;
        fixed_form = 1'b1;
        round_sel = 1'b1;
      end
      packed_shift_pkg::OP_FIX_PH: fixed_form = 1'b1;
      packed_shift_pkg::OP_FIX_PH_R: begin
        fixed_form = 1'b1;
        round_sel = 1'b1;
      end
      packed_shift_pkg::OP_VAR_PH_R: round_sel = 1'b1;
      packed_shift_pkg::OP_VAR_QB: byte_mode = 1'b1;
      packed_shift_pkg::OP_VAR_QB_R: begin
        byte_mode = 1'b1;
        round_sel = 1'b1;
      end
      default: ;
    endcase
  end

  // fixed forms read the source register, variable ones the target
  assign operand = fixed_form ? source_field_in : target_field_in;
  // variable forms ignore every count bit above the lane's width
  assign qb_amt = fixed_form
                  ? instr_in[`PSH_QB_SA_MSB:`PSH_QB_SA_LSB]
                  : source_field_in[`PSH_QB_CNT_MSB:`PSH_CNT_LSB];
  assign ph_amt = fixed_form
                  ? instr_in[`PSH_PH_SA_MSB:`PSH_PH_SA_LSB]
                  : source_field_in[`PSH_PH_CNT_MSB:`PSH_CNT_LSB];

  // ==================================================================
  // lanes
  logic [31:0] qb_res;
  logic [31:0] ph_res;

  // each lane rounds in its own width+1 bits, so carries stay local
  for (genvar i = 0; i < 4; i++) begin : g_qb
    lane_arith_shift #(.WIDTH(8), .SW(3)) u_lane (
      .value_in(operand[8*i +: 8]),
      .amount_in(qb_amt),
      .round_in(round_sel),
      .result_out(qb_res[8*i +: 8])
    );
  end
  for (genvar j = 0; j < 2; j++) begin : g_ph
    lane_arith_shift #(.WIDTH(16), .SW(4)) u_lane (
      .value_in(operand[16*j +: 16]),
      .amount_in(ph_amt),
      .round_in(round_sel),
      .result_out(ph_res[16*j +: 16])
    );
  end

  // unknown words take the halfword path; nothing is written back for them
  logic [31:0] next_result;
  assign next_result = byte_mode ? qb_res : ph_res;

  // ==================================================================
  // access check and exception
  packed_shift_pkg::exc_code_t exc;
  logic commit;
  always_comb begin
    // only access checks raise exceptions; data never does
    exc = `PSH_EXC_NONE;
    if (known) begin
      if (!dsp_present_in) begin
        exc = `PSH_EXC_RESERVED;
      end else if (!dsp_enabled_in) begin
        exc = `PSH_EXC_DSP_OFF;
      end
    end
  end
  assign commit = issue_in && known && (exc == `PSH_EXC_NONE);

  // ==================================================================
  // result register
  // one-cycle pulses that frame each issue
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_out <= 1'b0;
      decoded_out <= 1'b0;
      write_en_out <= 1'b0;
    end else begin
      done_out <= issue_in;
      decoded_out <= issue_in && known;
      write_en_out <= commit;
    end
  end

  // the exception code stands only with its done pulse
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      exc_out <= `PSH_EXC_NONE;
    end else begin
      exc_out <= issue_in ? exc : `PSH_EXC_NONE;
    end
  end

  // index and data hold until the next issue
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dest_reg_out <= `PSH_DEST_RST;
    end else if (issue_in) begin
      dest_reg_out <= dest;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result_out <= `PSH_RESULT_RST;
    end else if (issue_in) begin
      result_out <= next_result;
    end
  end
endmodule : packed_arith_right_shifter
`default_nettype wire

// File: dv/packed_shift_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checks
module packed_shift_chk (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic issue_in,
  input wire logic done_out,
  input wire logic dsp_present_in,
  input wire logic dsp_enabled_in,
  input wire logic write_en_out,
  input wire logic decoded_out,
  input wire logic [31:0] instr_in,
  input wire logic [31:0] source_field_in,
  input wire logic [31:0] target_field_in,
  input wire logic [31:0] result_out,
  input wire logic [4:0] dest_reg_out,
  input wire logic [1:0] exc_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_var;
    issue_in && instr_in[31:26] == 6'h08 && instr_in[2:0] == 3'h5
      && instr_in[9:3] inside {7'h31, 7'h39};
  endsequence
  sequence s_open;
    s_var ##0 dsp_present_in && dsp_enabled_in;
  endsequence
  a_done_follows: assert property (issue_in |=> done_out)
    else $error("done missing");
  a_no_stray: assert property (!issue_in |=> !done_out)
    else $error("stray done");
  a_absent_blocks: assert property (issue_in && !dsp_present_in
    |=> !write_en_out && exc_out != 2'h0) else $error("absent wrote");
  a_off_blocks: assert property (issue_in && !dsp_enabled_in
    |=> !write_en_out) else $error("disabled wrote");
  a_write_clean: assert property (write_en_out |-> decoded_out
    && exc_out == 2'h0) else $error("dirty write");
  a_result_holds: assert property (!done_out |-> $stable(result_out))
    else $error("result moved");
  a_var_dest: assert property (s_var
    |=> dest_reg_out == $past(instr_in[15:11])) else $error("bad dest");
  a_var_write: assert property (s_open |=> write_en_out && decoded_out)
    else $error("var form lost");
  a_var_zero: assert property (s_open ##0 source_field_in[3:0] == 4'h0
    |=> result_out == $past(target_field_in)) else $error("zero shift");
endmodule : packed_shift_chk
bind packed_arith_right_shifter packed_shift_chk u_chk (.*);
`default_nettype wire

// File: dv/shift_regfile_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// register file: read ports follow the fields with no bypass
module shift_regfile_model (
  input wire logic clk_in,
  input wire logic [31:0] instr_in,
  input wire logic wr_in,
  input wire logic [4:0] wr_idx_in,
  input wire logic [31:0] wr_data_in,
  input wire logic load_in,
  input wire logic [31:0] load_src_in,
  input wire logic [31:0] load_tgt_in,
  output logic [31:0] src_out,
  output logic [31:0] tgt_out
);
  logic [31:0] regs [32];
  assign src_out = regs[instr_in[20:16]];
  assign tgt_out = regs[instr_in[25:21]];
  always_ff @(posedge clk_in) begin
    if (wr_in) begin
      regs[wr_idx_in] <= wr_data_in;
    end
    // a preload of the fields' registers wins over a writeback
    if (load_in) begin
      regs[instr_in[20:16]] <= load_src_in;
      regs[instr_in[25:21]] <= load_tgt_in;
    end
  end
endmodule : shift_regfile_model
`default_nettype wire

// File: dv/packed_arith_right_shifter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module packed_arith_right_shifter_tb_top;
  logic clk_in = 0, nrst_in = 0, issue = 0, pres = 1, ena = 1;
  logic [31:0] instr = 0, src, tgt, result;
  logic done, wen, dec;
  logic [4:0] dest;
  logic [1:0] exc;
  logic load = 0;
  logic [31:0] src_ld = 0, tgt_ld = 0;
  int fail_count = 0, num_checks = 0, seed = 32'h882f;
  initial forever #12.5 clk_in = ~clk_in;
  packed_arith_right_shifter u_dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .issue_in(issue), .instr_in(instr), .source_field_in(src),
    .target_field_in(tgt), .dsp_present_in(pres), .dsp_enabled_in(ena),
    .done_out(done), .result_out(result), .dest_reg_out(dest),
    .write_en_out(wen), .exc_out(exc), .decoded_out(dec));
  shift_regfile_model u_rf (.clk_in(clk_in), .instr_in(instr),
    .wr_in(wen), .wr_idx_in(dest), .wr_data_in(result), .load_in(load),
    .load_src_in(src_ld), .load_tgt_in(tgt_ld), .src_out(src),
    .tgt_out(tgt));
  // ==========
  // expectations: 18-bit signed keeps the rounding carry inside the lane
  function automatic logic [15:0] lane(logic [15:0] v, int w, int s, bit r);
    logic signed [17:0] x;
    x = (w == 8) ? {{10{v[7]}}, v[7:0]} : {{2{v[15]}}, v};
    if (s == 0) return v;
    x = r ? (((x <<< 1) >>> s) + 1) >>> 1 : x >>> s;
    return x[15:0];
  endfunction : lane
  function automatic logic [31:0] calc(bit b, logic [31:0] v, int s, bit r);
    logic [15:0] t;
    for (int i = 0; i < 4; i++) begin
      t = lane(b ? 16'(v[8*i +: 8]) : v[16*(i/2) +: 16], b ? 8 : 16, s, r);
      if (b) calc[8*i +: 8] = t[7:0];
      else calc[16*(i/2) +: 16] = t;
    end
  endfunction : calc
  task automatic check(logic [31:0] seen, logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  // ==========
  // one issue: rt=1, rs=2, rd=3; high count bits are noise; k=4 is no form
  task automatic run(int k, bit r, int s);
    logic [31:0] want;
    logic [31:0] opnd_src;
    logic [31:0] opnd_tgt;
    @(negedge clk_in);
    opnd_tgt = $random(seed);
    opnd_src = k > 1 ? ($random(seed) << (k == 3 ? 3 : 4)) | s
      : $random(seed);
    case (k)
      0: instr = {6'h08, 5'd1, 5'd2, 3'(s), r, 12'h1ff};
      1: instr = {6'h08, 5'd1, 5'd2, 4'(s), 1'b0, r, 7'h66, 3'h5};
      4: instr = {6'h09, 26'($random(seed))};
      default: instr = {6'h08, 5'd1, 5'd2, 5'd3, r,
        k == 2 ? 7'h31 : 7'h39, 3'h5};
    endcase
    // operands reach the register file one cycle ahead of the issue
    src_ld = opnd_src;
    tgt_ld = opnd_tgt;
    load = 1;
    @(negedge clk_in);
    load = 0;
    want = calc(k == 0 || k == 3, k < 2 ? opnd_src : opnd_tgt, s, r);
    issue = 1;
    @(negedge clk_in);
    issue = 0;
    if (pres && ena && k < 4) check(result, want);
    if (k < 4) check(32'(dest), k < 2 ? 1 : 3);
    check(32'({done, wen, dec, exc}),
      k == 4 ? 16 : !pres ? 21 : !ena ? 22 : 28);
  endtask : run
  task automatic give_verdict;
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (16) @(negedge clk_in);
    nrst_in = 1;
    for (int k = 0; k < 4; k++) begin
      for (int r = 0; r < 2; r++) begin
        run(k, r, 0);
        run(k, r, k[0] == k[1] ? 7 : 15);
        repeat (8) run(k, r, $random(seed) & (k[0] == k[1] ? 7 : 15));
      end
    end
    repeat (8) run(4, 0, 0);
    pres = 0;
    run(2, 1, 5);
    pres = 1;
    ena = 0;
    run(3, 0, 3);
    ena = 1;
    give_verdict();
  end
endmodule : packed_arith_right_shifter_tb_top
`default_nettype wire
